// ==== design/drd_regs.svh ====
// Operation
// - 24-bit frame: rw, device, select, channel, data
// - select 010 loads one channel gain
// - select 011 loads gain of all channels
// - gain straight binary, resets to FFFF
// - select 100 loads one channel offset
// - select 101 loads offset of all channels
// - offset binary code, resets to 8000
// - select 110 stores channel clear code, reset 0
// - per-channel clear enable, set by dac control bit 2
// - select 111: bits 15-13 pick control register
// - control decode slew, main, dac, dcdc, software
// - main control bit layout, bits 7,3-0 ignored
// - act only when device bits match straps
// - channel field 00-11 selects channels A-D
`ifndef DRD_REGS_SVH
`define DRD_REGS_SVH

`define DRD_FRAME_W 24
`define DRD_RW_BIT 23
`define DRD_DEV_HI_BIT 22
`define DRD_DEV_LO_BIT 21
`define DRD_SEL_MSB 20
`define DRD_SEL_LSB 18
`define DRD_CHAN_MSB 17
`define DRD_CHAN_LSB 16
`define DRD_DATA_MSB 15
`define DRD_CTRL_MSB 15
`define DRD_CTRL_LSB 13
`define DRD_CDATA_MSB 12

`define DRD_POC_BIT 12
`define DRD_STATUS_READBACK_EN_BIT 11
`define DRD_WDOG_BIT 10
`define DRD_TSEL_HI_BIT 9
`define DRD_TSEL_LO_BIT 8
`define DRD_SHORT_BIT 6
`define DRD_OUTEN_BIT 5
`define DRD_CONV_BIT 4
`define DRD_CLR_EN_BIT 2

`define DRD_GAIN_RST 16'hFFFF
`define DRD_OFFSET_RST 16'h8000
`define DRD_CLEAR_RST 16'h0000
`define DRD_CLR_EN_RST 1'b0
`define DRD_MAIN_RST 8'h00

`endif

// ==== design/drd_pkg.sv ====
package drd_pkg;
   typedef enum logic [2:0] {
      DRD_SEL_DATA = 3'b000,
      DRD_SEL_RSVD = 3'b001,
      DRD_SEL_GAIN = 3'b010,
      DRD_SEL_GAIN_ALL = 3'b011,
      DRD_SEL_OFFSET = 3'b100,
      DRD_SEL_OFFSET_ALL = 3'b101,
      DRD_SEL_CLEAR = 3'b110,
      DRD_SEL_CTRL = 3'b111
   } drd_regsel_t;

   typedef enum logic [2:0] {
      DRD_CTRL_SLEW = 3'b000,
      DRD_CTRL_MAIN = 3'b001,
      DRD_CTRL_DAC = 3'b010,
      DRD_CTRL_DCDC = 3'b011,
      DRD_CTRL_SOFT = 3'b100
   } drd_ctrlsel_t;

   typedef struct packed {
      logic power_on_output_state;
      logic status_readback_en;
      logic watchdog_en;
      logic timeout_sel_hi;
      logic timeout_sel_lo;
      logic short_limit_sel;
      logic output_enable_every;
      logic converter_power_every;
   } drd_main_ctrl_t;
endpackage

// ==== design/drd_wr_if.sv ====
`timescale 1ns/1ps
interface drd_wr_if;
   logic [3:0] gain_we;
   logic [3:0] offset_we;
   logic [3:0] clear_we;
   logic [3:0] clr_en_we;
   logic clr_en_bit;
   logic [15:0] wr_data;
   modport src (
      output gain_we, offset_we, clear_we, clr_en_we, clr_en_bit, wr_data
   );
   modport dst (
      input gain_we, offset_we, clear_we, clr_en_we, clr_en_bit, wr_data
   );
endinterface

// ==== design/drd_channel_regs.sv ====
`timescale 1ns/1ps
`include "drd_regs.svh"
module drd_channel_regs
   import drd_pkg::*;
#(
   parameter int unsigned CH = 0
) (
   // clock and reset
   input wire logic clock_i,
   input wire logic reset_n_i,
   // write strobes
   drd_wr_if.dst wr,
   // clear pin
   input wire logic clear_i,
   // channel state
   output logic [15:0] gain_o,
   output logic [15:0] offset_o,
   output logic [15:0] clear_value_o,
   output logic clear_en_o,
   output logic clear_load_o
);
   logic [15:0] gain_q, gain_d;
   logic [15:0] offset_q, offset_d;
   logic [15:0] clear_q, clear_d;
   logic clr_en_q, clr_en_d;

   always_comb begin
      gain_d = gain_q;
      offset_d = offset_q;
      clear_d = clear_q;
      clr_en_d = clr_en_q;
      if (wr.gain_we[CH]) begin
         gain_d = wr.wr_data;
      end
      if (wr.offset_we[CH]) begin
         offset_d = wr.wr_data;
      end
      if (wr.clear_we[CH]) begin
         clear_d = wr.wr_data;
      end
      if (wr.clr_en_we[CH]) begin
         clr_en_d = wr.clr_en_bit;
      end
   end

   always_ff @(posedge clock_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         gain_q <= `DRD_GAIN_RST;
         offset_q <= `DRD_OFFSET_RST;
         clear_q <= `DRD_CLEAR_RST;
         clr_en_q <= `DRD_CLR_EN_RST;
      end else begin
         gain_q <= gain_d;
         offset_q <= offset_d;
         clear_q <= clear_d;
         clr_en_q <= clr_en_d;
      end
   end

   assign gain_o = gain_q;
   assign offset_o = offset_q;
   assign clear_value_o = clear_q;
   assign clear_en_o = clr_en_q;
   assign clear_load_o = clear_i & clr_en_q;

   a_gain_load: assert property (@(posedge clock_i)
      disable iff (!reset_n_i)
      wr.gain_we[CH] |=> gain_q == $past(wr.wr_data))
      else $error("gain not loaded");
   a_offset_hold: assert property (@(posedge clock_i)
      disable iff (!reset_n_i)
      !wr.offset_we[CH] |=> $stable(offset_q))
      else $error("offset changed without write");
   a_clear_load: assert property (@(posedge clock_i)
      disable iff (!reset_n_i)
      wr.clear_we[CH] |=> clear_q == $past(wr.wr_data))
      else $error("clear code not stored");
   a_enable_load: assert property (@(posedge clock_i)
      disable iff (!reset_n_i)
      wr.clr_en_we[CH] |=> clr_en_q == $past(wr.clr_en_bit))
      else $error("clear enable not stored");
endmodule

// ==== design/dac_register_decode.sv ====
`timescale 1ns/1ps
`include "drd_regs.svh"
module dac_register_decode
   import drd_pkg::*;
(
   // clock and reset
   input wire logic clock_i,
   input wire logic reset_n_i,
   // frame from the serial shifter
   input wire logic [23:0] frame_i,
   input wire logic frame_valid_i,
   // device address straps
   input wire logic dev_strap_hi_i,
   input wire logic dev_strap_lo_i,
   // clear pin
   input wire logic clear_i,
   // channel registers, channel A in slice 0
   output logic [3:0][15:0] gain_o,
   output logic [3:0][15:0] offset_o,
   output logic [3:0][15:0] clear_value_o,
   output logic [3:0] clear_en_o,
   output logic [3:0] clear_load_o,
   // main control
   output drd_main_ctrl_t main_ctrl_o,
   // control writes passed on
   output logic slew_wr_o,
   output logic dac_ctrl_wr_o,
   output logic dcdc_wr_o,
   output logic soft_wr_o,
   output logic [1:0] ctrl_chan_o,
   output logic [12:0] ctrl_data_o
);
   drd_wr_if wr ();

   logic rw_bit;
   logic device_sel_hi, device_sel_lo;
   logic channel_sel_hi, channel_sel_lo;
   logic [1:0] chan;
   drd_regsel_t reg_select;
   drd_ctrlsel_t ctrl_select;
   logic [15:0] data;
   logic dev_match, hit, ctrl_hit;
   logic [3:0] chan_dec;

   drd_main_ctrl_t main_q, main_d;
   logic slew_q, slew_d;
   logic dac_q, dac_d;
   logic dcdc_q, dcdc_d;
   logic soft_q, soft_d;
   logic [1:0] cchan_q, cchan_d;
   logic [12:0] cdata_q, cdata_d;

   // frame fields
   assign rw_bit = frame_i[`DRD_RW_BIT];
   assign device_sel_hi = frame_i[`DRD_DEV_HI_BIT];
   assign device_sel_lo = frame_i[`DRD_DEV_LO_BIT];
   assign reg_select = drd_regsel_t'(frame_i[`DRD_SEL_MSB:`DRD_SEL_LSB]);
   assign channel_sel_hi = frame_i[`DRD_CHAN_MSB];
   assign channel_sel_lo = frame_i[`DRD_CHAN_LSB];
   assign chan = {channel_sel_hi, channel_sel_lo};
   assign data = frame_i[`DRD_DATA_MSB:0];
   assign ctrl_select =
      drd_ctrlsel_t'(frame_i[`DRD_CTRL_MSB:`DRD_CTRL_LSB]);

   // address match and write qualification
   assign dev_match = (device_sel_hi == dev_strap_hi_i) &&
                      (device_sel_lo == dev_strap_lo_i);
   assign hit = frame_valid_i && !rw_bit && dev_match;
   assign ctrl_hit = hit && (reg_select == DRD_SEL_CTRL);

   // one-hot channel decode
   always_comb begin
      chan_dec = 4'h0;
      chan_dec[chan] = 1'b1;
   end

   // channel register strobes
   always_comb begin
      wr.gain_we = 4'h0;
      wr.offset_we = 4'h0;
      wr.clear_we = 4'h0;
      wr.clr_en_we = 4'h0;
      wr.wr_data = data;
      wr.clr_en_bit = data[`DRD_CLR_EN_BIT];
      if (hit) begin
         unique case (reg_select)
            DRD_SEL_GAIN: wr.gain_we = chan_dec;
            DRD_SEL_GAIN_ALL: wr.gain_we = 4'hF;
            DRD_SEL_OFFSET: wr.offset_we = chan_dec;
            DRD_SEL_OFFSET_ALL: wr.offset_we = 4'hF;
            DRD_SEL_CLEAR: wr.clear_we = chan_dec;
            DRD_SEL_CTRL: begin
               if (ctrl_select == DRD_CTRL_DAC) begin
                  wr.clr_en_we = chan_dec;
               end
            end
            DRD_SEL_DATA, DRD_SEL_RSVD: begin
               wr.gain_we = 4'h0;
            end
         endcase
      end
   end

   // control register decode
   always_comb begin
      main_d = main_q;
      slew_d = 1'b0;
      dac_d = 1'b0;
      dcdc_d = 1'b0;
      soft_d = 1'b0;
      cchan_d = cchan_q;
      cdata_d = cdata_q;
      if (ctrl_hit) begin
         unique case (ctrl_select)
            DRD_CTRL_SLEW: slew_d = 1'b1;
            DRD_CTRL_MAIN: begin
               main_d.power_on_output_state = data[`DRD_POC_BIT];
               main_d.status_readback_en = data[`DRD_STATUS_READBACK_EN_BIT];
               main_d.watchdog_en = data[`DRD_WDOG_BIT];
               main_d.timeout_sel_hi = data[`DRD_TSEL_HI_BIT];
               main_d.timeout_sel_lo = data[`DRD_TSEL_LO_BIT];
               main_d.short_limit_sel = data[`DRD_SHORT_BIT];
               main_d.output_enable_every = data[`DRD_OUTEN_BIT];
               main_d.converter_power_every = data[`DRD_CONV_BIT];
            end
            DRD_CTRL_DAC: dac_d = 1'b1;
            DRD_CTRL_DCDC: dcdc_d = 1'b1;
            DRD_CTRL_SOFT: soft_d = 1'b1;
            default: main_d = main_q;
         endcase
         if (slew_d || dac_d || dcdc_d || soft_d) begin
            cchan_d = chan;
            cdata_d = data[`DRD_CDATA_MSB:0];
         end
      end
   end

   always_ff @(posedge clock_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         main_q <= `DRD_MAIN_RST;
         slew_q <= 1'b0;
         dac_q <= 1'b0;
         dcdc_q <= 1'b0;
         soft_q <= 1'b0;
         cchan_q <= 2'h0;
         cdata_q <= 13'h0000;
      end else begin
         main_q <= main_d;
         slew_q <= slew_d;
         dac_q <= dac_d;
         dcdc_q <= dcdc_d;
         soft_q <= soft_d;
         cchan_q <= cchan_d;
         cdata_q <= cdata_d;
      end
   end

   assign main_ctrl_o = main_q;
   assign slew_wr_o = slew_q;
   assign dac_ctrl_wr_o = dac_q;
   assign dcdc_wr_o = dcdc_q;
   assign soft_wr_o = soft_q;
   assign ctrl_chan_o = cchan_q;
   assign ctrl_data_o = cdata_q;

   // per-channel calibration state
   for (genvar i = 0; i < 4; i++) begin : g_chan
      drd_channel_regs #(
         .CH(i)
      ) i_drd_channel_regs (
         .clock_i(clock_i),
         .reset_n_i(reset_n_i),
         .wr(wr),
         .clear_i(clear_i),
         .gain_o(gain_o[i]),
         .offset_o(offset_o[i]),
         .clear_value_o(clear_value_o[i]),
         .clear_en_o(clear_en_o[i]),
         .clear_load_o(clear_load_o[i])
      );
   end

   // checks
   a_foreign_device: assert property (@(posedge clock_i)
      disable iff (!reset_n_i)
      (frame_valid_i && !dev_match) |=> $stable(gain_o) && $stable(offset_o)
         && $stable(clear_value_o) && $stable(main_q))
      else $error("foreign device frame changed state");
   a_read_ignored: assert property (@(posedge clock_i)
      disable iff (!reset_n_i)
      (frame_valid_i && rw_bit) |=> $stable(gain_o) && $stable(main_q)
         && !slew_q && !dac_q && !dcdc_q && !soft_q)
      else $error("read frame acted as write");
   a_data_sel_ignored: assert property (@(posedge clock_i)
      disable iff (!reset_n_i)
      (hit && reg_select inside {DRD_SEL_DATA, DRD_SEL_RSVD}) |=>
         $stable(gain_o) && $stable(offset_o) && $stable(clear_value_o)
         && !slew_q && !dac_q && !dcdc_q && !soft_q)
      else $error("data register frame acted");
   a_gain_single: assert property (@(posedge clock_i)
      disable iff (!reset_n_i)
      (hit && reg_select == DRD_SEL_GAIN) |=>
         gain_o[$past(chan)] == $past(data)
         && ((gain_o ^ $past(gain_o))
            & ~(64'h0000_0000_0000_FFFF << (16 * $past(chan)))) == 64'h0)
      else $error("single gain write wrong");
   a_gain_bcast: assert property (@(posedge clock_i)
      disable iff (!reset_n_i)
      (hit && reg_select == DRD_SEL_GAIN_ALL) |=>
         gain_o == {4{$past(data)}})
      else $error("broadcast gain missed a channel");
   a_offset_single: assert property (@(posedge clock_i)
      disable iff (!reset_n_i)
      (hit && reg_select == DRD_SEL_OFFSET) |=>
         offset_o[$past(chan)] == $past(data)
         && ((offset_o ^ $past(offset_o))
            & ~(64'h0000_0000_0000_FFFF << (16 * $past(chan)))) == 64'h0)
      else $error("single offset write wrong");
   a_offset_bcast: assert property (@(posedge clock_i)
      disable iff (!reset_n_i)
      (hit && reg_select == DRD_SEL_OFFSET_ALL) |=>
         offset_o == {4{$past(data)}})
      else $error("broadcast offset missed a channel");
   a_clear_store: assert property (@(posedge clock_i)
      disable iff (!reset_n_i)
      (hit && reg_select == DRD_SEL_CLEAR) |=>
         clear_value_o[$past(chan)] == $past(data)
         && $stable(gain_o))
      else $error("clear code write wrong");

   // nothing moves without its own write
   a_gain_hold: assert property (@(posedge clock_i)
      disable iff (!reset_n_i)
      !(hit && reg_select inside {DRD_SEL_GAIN, DRD_SEL_GAIN_ALL}) |=>
         $stable(gain_o))
      else $error("gain changed without write");
   a_clear_hold: assert property (@(posedge clock_i)
      disable iff (!reset_n_i)
      !(hit && reg_select == DRD_SEL_CLEAR) |=> $stable(clear_value_o))
      else $error("clear code changed without write");
   a_enable_hold: assert property (@(posedge clock_i)
      disable iff (!reset_n_i)
      !(ctrl_hit && ctrl_select == DRD_CTRL_DAC) |=> $stable(clear_en_o))
      else $error("clear enable changed without write");
   a_main_hold: assert property (@(posedge clock_i)
      disable iff (!reset_n_i)
      !(ctrl_hit && ctrl_select == DRD_CTRL_MAIN) |=> $stable(main_q))
      else $error("main control changed without write");
   a_cdata_hold: assert property (@(posedge clock_i)
      disable iff (!reset_n_i)
      !(ctrl_hit && ctrl_select inside {DRD_CTRL_SLEW, DRD_CTRL_DAC,
         DRD_CTRL_DCDC, DRD_CTRL_SOFT}) |=>
         $stable(ctrl_data_o) && $stable(ctrl_chan_o))
      else $error("control data changed without write");

   a_main_layout: assert property (@(posedge clock_i)
      disable iff (!reset_n_i)
      (ctrl_hit && ctrl_select == DRD_CTRL_MAIN) |=>
         main_q == {$past(data[12:8]), $past(data[6:4])})
      else $error("main control fields misplaced");
   a_ctrl_undef: assert property (@(posedge clock_i)
      disable iff (!reset_n_i)
      (ctrl_hit && frame_i[15:13] > 3'b100) |=> $stable(main_q)
         && $stable(gain_o) && !slew_q && !dac_q && !dcdc_q && !soft_q
         && $stable(clear_en_o))
      else $error("undefined control write acted");
   a_ctrl_route: assert property (@(posedge clock_i)
      disable iff (!reset_n_i)
      (ctrl_hit && ctrl_select == DRD_CTRL_DCDC) |=>
         dcdc_q && !slew_q && ctrl_data_o == $past(data[12:0]))
      else $error("control sub-address misrouted");
   a_slew_route: assert property (@(posedge clock_i)
      disable iff (!reset_n_i)
      (ctrl_hit && ctrl_select == DRD_CTRL_SLEW) |=>
         slew_q && !dac_q && !dcdc_q && !soft_q
         && ctrl_chan_o == $past(chan)
         && ctrl_data_o == $past(data[12:0]))
      else $error("slew control write misrouted");
   a_dac_route: assert property (@(posedge clock_i)
      disable iff (!reset_n_i)
      (ctrl_hit && ctrl_select == DRD_CTRL_DAC) |=>
         dac_q && !slew_q && !dcdc_q && !soft_q
         && clear_en_o[$past(chan)] == $past(data[`DRD_CLR_EN_BIT]))
      else $error("dac control write misrouted");
   a_soft_route: assert property (@(posedge clock_i)
      disable iff (!reset_n_i)
      (ctrl_hit && ctrl_select == DRD_CTRL_SOFT) |=>
         soft_q && !slew_q && !dac_q && !dcdc_q)
      else $error("software write misrouted");
   a_pulse_source: assert property (@(posedge clock_i)
      disable iff (!reset_n_i)
      (slew_q || dac_q || dcdc_q || soft_q) |->
         $past(ctrl_hit))
      else $error("control pulse without control write");

   c_gain_bcast: cover property (@(posedge clock_i) disable iff (!reset_n_i)
      hit && reg_select == DRD_SEL_GAIN_ALL);
   c_ctrl_undef: cover property (@(posedge clock_i) disable iff (!reset_n_i)
      ctrl_hit && frame_i[15:13] > 3'b100);
   c_main_write: cover property (@(posedge clock_i) disable iff (!reset_n_i)
      ctrl_hit && ctrl_select == DRD_CTRL_MAIN);
   c_foreign: cover property (@(posedge clock_i) disable iff (!reset_n_i)
      frame_valid_i && !dev_match);
   c_clear_load: cover property (@(posedge clock_i) disable iff (!reset_n_i)
      |clear_load_o);
endmodule

// ==== bench/drd_host_model.sv ====
`timescale 1ns/1ps
module drd_host_model (
   // clock
   input wire logic clock_i,
   // frame to the decoder
   output logic [23:0] frame_o,
   output logic frame_valid_o
);
   initial begin
      frame_o = 24'h000000;
      frame_valid_o = 1'b0;
   end
   // one whole 24-bit frame per valid pulse, released lines show inverse
   task automatic send(input logic [23:0] f);
      @(posedge clock_i);
      frame_o <= f;
      frame_valid_o <= 1'b1;
      @(posedge clock_i);
      frame_o <= ~f;
      frame_valid_o <= 1'b0;
   endtask
endmodule

// ==== bench/dac_register_decode_tb.sv ====
`timescale 1ns/1ps
module dac_register_decode_tb;
   import drd_pkg::*;
   logic clock_i = 1'b0;
   logic reset_n_i = 1'b0;
   logic [23:0] frame;
   logic frame_valid;
   logic [1:0] strap = 2'b10;
   logic clear = 1'b0;
   logic [3:0][15:0] gain, offset, clr_val;
   logic [3:0] clr_en, clr_load;
   drd_main_ctrl_t main_ctrl;
   logic slew_wr, dac_wr, dcdc_wr, soft_wr;
   logic [1:0] cchan;
   logic [12:0] cdata;
   logic [15:0] pcnt [4];
   int err_total = 0;
   int num_checks = 0;

   always #2 clock_i = ~clock_i;

   drd_host_model i_drd_host_model (
      .clock_i(clock_i),
      .frame_o(frame),
      .frame_valid_o(frame_valid)
   );

   dac_register_decode i_dac_register_decode (
      .clock_i(clock_i),
      .reset_n_i(reset_n_i),
      .frame_i(frame),
      .frame_valid_i(frame_valid),
      .dev_strap_hi_i(strap[1]),
      .dev_strap_lo_i(strap[0]),
      .clear_i(clear),
      .gain_o(gain),
      .offset_o(offset),
      .clear_value_o(clr_val),
      .clear_en_o(clr_en),
      .clear_load_o(clr_load),
      .main_ctrl_o(main_ctrl),
      .slew_wr_o(slew_wr),
      .dac_ctrl_wr_o(dac_wr),
      .dcdc_wr_o(dcdc_wr),
      .soft_wr_o(soft_wr),
      .ctrl_chan_o(cchan),
      .ctrl_data_o(cdata)
   );

   task automatic results;
      if (err_total == 0 && num_checks > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      num_checks++;
      if (got !== exp) begin
         err_total++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic chk4(input logic [3:0][15:0] got,
                       input logic [3:0][15:0] exp);
      for (int k = 0; k < 4; k++) begin
         chk(got[k], exp[k]);
      end
   endtask

   // send a frame, then count control pulses over four cycles
   task automatic wr(input logic [2:0] sel, input logic [1:0] ch,
                     input logic [15:0] d, input logic [1:0] dev = 2'b10,
                     input logic rw = 1'b0);
      logic [3:0] ps;
      for (int k = 0; k < 4; k++) begin
         pcnt[k] = 16'h0000;
      end
      i_drd_host_model.send({rw, dev, sel, ch, d});
      repeat (4) begin
         #1;
         ps = {soft_wr, dcdc_wr, dac_wr, slew_wr};
         for (int k = 0; k < 4; k++) begin
            pcnt[k] = pcnt[k] + {15'h0000, ps[k]};
         end
         @(posedge clock_i);
      end
   endtask

   initial begin
      repeat (20000) @(posedge clock_i);
      err_total++;
      results();
   end

   initial begin
      int e;
      repeat (5) @(posedge clock_i);
      reset_n_i <= 1'b1;
      wr(3'b010, 2'b00, 16'h1111, 2'b01);
      wr(3'b010, 2'b00, 16'h2222, 2'b10, 1'b1);
      wr(3'b000, 2'b00, 16'h3333);
      wr(3'b001, 2'b00, 16'h4444);
      chk4(gain, {4{16'hFFFF}});
      chk4(offset, {4{16'h8000}});
      chk4(clr_val, {4{16'h0000}});
      chk({12'h000, clr_en}, 16'h0000);
      chk({8'h00, main_ctrl}, 16'h0000);
      // gain trims kept near half range
      wr(3'b010, 2'b11, 16'h7FFF);
      chk4(gain, {16'h7FFF, {3{16'hFFFF}}});
      wr(3'b011, 2'b01, 16'h8001);
      chk4(gain, {4{16'h8001}});
      wr(3'b101, 2'b10, 16'h0000);
      chk4(offset, {4{16'h0000}});
      wr(3'b100, 2'b00, 16'hFFFF);
      chk4(offset, {{3{16'h0000}}, 16'hFFFF});
      wr(3'b110, 2'b01, 16'hBEEF);
      chk4(clr_val, {16'h0000, 16'h0000, 16'hBEEF, 16'h0000});
      for (int s = 0; s < 8; s++) begin
         e = (s == 0) ? 0 : (s == 2) ? 1 : (s == 3) ? 2 : (s == 4) ? 3 : -1;
         wr(3'b111, 2'(s), {3'(s), 13'h0A5A + 13'(s)});
         for (int k = 0; k < 4; k++) begin
            chk(pcnt[k], (k == e) ? 16'h0001 : 16'h0000);
         end
         if (e >= 0) begin
            chk({3'h0, cdata}, 16'h0A5A + 16'(s));
            chk({14'h0000, cchan}, 16'(s % 4));
         end
      end
      chk({3'h0, cdata}, 16'h0A5E);
      chk({8'h00, main_ctrl}, 16'h0055);
      chk4(gain, {4{16'h8001}});
      wr(3'b111, 2'b00, {3'b001, 13'h1F70});
      chk({8'h00, main_ctrl}, 16'h00FF);
      wr(3'b111, 2'b00, {3'b001, 13'h008F});
      chk({8'h00, main_ctrl}, 16'h0000);
      wr(3'b111, 2'b10, {3'b010, 13'h0004});
      chk({12'h000, clr_en}, 16'h0004);
      chk({12'h000, clr_load}, 16'h0000);
      @(posedge clock_i);
      clear <= 1'b1;
      @(posedge clock_i);
      #1;
      chk({12'h000, clr_load}, 16'h0004);
      wr(3'b111, 2'b10, {3'b010, 13'h0000});
      chk({12'h000, clr_en}, 16'h0000);
      chk({12'h000, clr_load}, 16'h0000);
      @(posedge clock_i);
      strap <= 2'b01;
      wr(3'b010, 2'b01, 16'h1357, 2'b01);
      wr(3'b010, 2'b01, 16'h2468);
      chk(gain[1], 16'h1357);
      results();
   end
endmodule
